/* rtl/tpg_pkg.sv */
// constants for the converter test-pattern generator
// Function
// - select code 0000 passes normal converter samples for channels A and B.
// - select code 0001 outputs words of all zero bits.
// - select code 0010 outputs words of all one bits.
// - select code 0011 alternates 1010 and 0101 words each sample.
// - select code 0100 outputs a ramp rising one code per cycle.
// - select code 0110 outputs the first custom word.
// - select code 0111 alternates first and second custom words.
// - select code 1000 outputs deskew value 7fff, cut to word width.
// - first custom word: bits 13-6 in one register, 5-0 in next bits 7-2.
// - second custom word built the same way from its own register pair.
// - reset clears select and both custom words, giving normal data.
package tpg_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_PATTERN_SELECT = 8'h74;
	localparam logic [7:0] OFS_WORD_ONE_HIGH  = 8'h75;
	localparam logic [7:0] OFS_WORD_ONE_LOW   = 8'h76;
	localparam logic [7:0] OFS_WORD_TWO_HIGH  = 8'h77;
	localparam logic [7:0] OFS_WORD_TWO_LOW   = 8'h78;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int         SEL_LSB     = 4;
	localparam int         LOW_LSB     = 2;
	localparam logic [3:0] SEL_RESET   = 4'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic [7:0] READ_UNMAP  = 8'h00;
	// ----------------------------------------
	// pattern codes
	// ----------------------------------------
	localparam logic [3:0] PAT_NORMAL  = 4'h0;
	localparam logic [3:0] PAT_ZEROS   = 4'h1;
	localparam logic [3:0] PAT_ONES    = 4'h2;
	localparam logic [3:0] PAT_TOGGLE  = 4'h3;
	localparam logic [3:0] PAT_RAMP    = 4'h4;
	localparam logic [3:0] PAT_SINGLE  = 4'h6;
	localparam logic [3:0] PAT_DOUBLE  = 4'h7;
	localparam logic [3:0] PAT_DESKEW  = 4'h8;
	localparam logic [15:0] DESKEW_VAL = 16'h7fff;
	localparam logic [15:0] TOGGLE_VAL = 16'haaaa;
endpackage : tpg_pkg

/* rtl/adc_test_pattern_generator.sv */
// test-pattern generator replacing converter samples on channels A and B
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module adc_test_pattern_generator #(
	parameter int W = 14
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// register port
	input  wire logic [7:0]   i_addr,
	input  wire logic [7:0]   i_wdata,
	input  wire logic         i_wr,
	input  wire logic         i_rd,
	output logic      [7:0]   o_rdata,
	// converter samples in
	input  wire logic [W-1:0] i_sample_a,
	input  wire logic [W-1:0] i_sample_b,
	// samples toward the serializer
	output logic      [W-1:0] o_sample_a,
	output logic      [W-1:0] o_sample_b
);
	// ----------------------------------------
	// local sizes
	// ----------------------------------------
	localparam int LANES = 2;
	localparam int SEL_W = 4;
	localparam int HI_W  = 8;
	localparam int LO_W  = 6;
	localparam int RD_W  = 8;

	// ----------------------------------------
	// registered state
	// ----------------------------------------
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [HI_W-1:0]  one_hi;
		logic [LO_W-1:0]  one_lo;
		logic [HI_W-1:0]  two_hi;
		logic [LO_W-1:0]  two_lo;
		logic [W-1:0]     ramp;
		logic             phase;
		logic [RD_W-1:0]  rdata;
		logic [W-1:0]     out_a;
		logic [W-1:0]     out_b;
	} state_s;

	state_s st;
	state_s next_st;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic hit_sel;
	logic hit_one_hi;
	logic hit_one_lo;
	logic hit_two_hi;
	logic hit_two_lo;
	logic hit_any;

	assign hit_sel    = (i_addr == tpg_pkg::OFS_PATTERN_SELECT);
	assign hit_one_hi = (i_addr == tpg_pkg::OFS_WORD_ONE_HIGH);
	assign hit_one_lo = (i_addr == tpg_pkg::OFS_WORD_ONE_LOW);
	assign hit_two_hi = (i_addr == tpg_pkg::OFS_WORD_TWO_HIGH);
	assign hit_two_lo = (i_addr == tpg_pkg::OFS_WORD_TWO_LOW);
	assign hit_any    = hit_sel | hit_one_hi | hit_one_lo | hit_two_hi | hit_two_lo;

	// ----------------------------------------
	// write data fields
	// ----------------------------------------
	logic [SEL_W-1:0] wd_sel;
	logic [HI_W-1:0]  wd_hi;
	logic [LO_W-1:0]  wd_lo;

	assign wd_sel = i_wdata[tpg_pkg::SEL_LSB +: SEL_W];
	assign wd_hi  = i_wdata[HI_W-1:0];
	assign wd_lo  = i_wdata[tpg_pkg::LOW_LSB +: LO_W];

	// ----------------------------------------
	// write strobes per register
	// ----------------------------------------
	logic wr_sel;
	logic wr_one_hi;
	logic wr_one_lo;
	logic wr_two_hi;
	logic wr_two_lo;

	assign wr_sel    = i_wr & hit_sel;
	assign wr_one_hi = i_wr & hit_one_hi;
	assign wr_one_lo = i_wr & hit_one_lo;
	assign wr_two_hi = i_wr & hit_two_hi;
	assign wr_two_lo = i_wr & hit_two_lo;

	// ----------------------------------------
	// read strobes per register
	// ----------------------------------------
	logic rd_en_sel;
	logic rd_en_one_hi;
	logic rd_en_one_lo;
	logic rd_en_two_hi;
	logic rd_en_two_lo;

	assign rd_en_sel    = i_rd & hit_sel;
	assign rd_en_one_hi = i_rd & hit_one_hi;
	assign rd_en_one_lo = i_rd & hit_one_lo;
	assign rd_en_two_hi = i_rd & hit_two_hi;
	assign rd_en_two_lo = i_rd & hit_two_lo;

	// ----------------------------------------
	// read data per register
	// ----------------------------------------
	logic [RD_W-1:0] rd_sel;
	logic [RD_W-1:0] rd_one_hi;
	logic [RD_W-1:0] rd_one_lo;
	logic [RD_W-1:0] rd_two_hi;
	logic [RD_W-1:0] rd_two_lo;

	assign rd_sel    = {st.sel, {tpg_pkg::SEL_LSB{1'b0}}};
	assign rd_one_hi = st.one_hi;
	assign rd_one_lo = {st.one_lo, {tpg_pkg::LOW_LSB{1'b0}}};
	assign rd_two_hi = st.two_hi;
	assign rd_two_lo = {st.two_lo, {tpg_pkg::LOW_LSB{1'b0}}};

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [RD_W-1:0] rd_mux;

	assign rd_mux = ({RD_W{rd_en_sel}} & rd_sel)
	              | ({RD_W{rd_en_one_hi}} & rd_one_hi)
	              | ({RD_W{rd_en_one_lo}} & rd_one_lo)
	              | ({RD_W{rd_en_two_hi}} & rd_two_hi)
	              | ({RD_W{rd_en_two_lo}} & rd_two_lo);

	// ----------------------------------------
	// custom words
	// ----------------------------------------
	logic [W-1:0] word_one;
	logic [W-1:0] word_two;

	assign word_one = W'({st.one_hi, st.one_lo});
	assign word_two = W'({st.two_hi, st.two_lo});

	// ----------------------------------------
	// pattern code decode
	// ----------------------------------------
	logic is_normal;
	logic is_zeros;
	logic is_ones;
	logic is_toggle;
	logic is_ramp;
	logic is_single;
	logic is_double;
	logic is_deskew;

	assign is_normal = (st.sel == tpg_pkg::PAT_NORMAL);
	assign is_zeros  = (st.sel == tpg_pkg::PAT_ZEROS);
	assign is_ones   = (st.sel == tpg_pkg::PAT_ONES);
	assign is_toggle = (st.sel == tpg_pkg::PAT_TOGGLE);
	assign is_ramp   = (st.sel == tpg_pkg::PAT_RAMP);
	assign is_single = (st.sel == tpg_pkg::PAT_SINGLE);
	assign is_double = (st.sel == tpg_pkg::PAT_DOUBLE);
	assign is_deskew = (st.sel == tpg_pkg::PAT_DESKEW);

	// ----------------------------------------
	// pattern enable
	// ----------------------------------------
	logic code_listed;
	logic use_pat;

	assign code_listed = is_zeros | is_ones | is_toggle | is_ramp
	                   | is_single | is_double | is_deskew;
	assign use_pat     = ~is_normal & code_listed;

	// ----------------------------------------
	// ramp counter
	// ----------------------------------------
	logic [W-1:0] ramp_top;
	logic         ramp_at_top;
	logic [W-1:0] ramp_step;

	assign ramp_top    = {W{1'b1}};
	assign ramp_at_top = (st.ramp == ramp_top);
	assign ramp_step   = ramp_at_top ? {W{1'b0}} : st.ramp + W'(1);

	// ----------------------------------------
	// alternation phase
	// ----------------------------------------
	logic next_phase;

	assign next_phase = ~st.phase;

	// ----------------------------------------
	// fixed and alternating words
	// ----------------------------------------
	logic [W-1:0] toggle_base;
	logic [W-1:0] toggle_word;
	logic [W-1:0] double_word;
	logic [W-1:0] deskew_word;

	assign toggle_base = W'(tpg_pkg::TOGGLE_VAL);
	assign toggle_word = st.phase ? ~toggle_base : toggle_base;
	assign double_word = st.phase ? word_two : word_one;
	assign deskew_word = W'(tpg_pkg::DESKEW_VAL);

	// ----------------------------------------
	// pattern terms
	// ----------------------------------------
	logic [W-1:0] term_zeros;
	logic [W-1:0] term_ones;
	logic [W-1:0] term_toggle;
	logic [W-1:0] term_ramp;
	logic [W-1:0] term_single;
	logic [W-1:0] term_double;
	logic [W-1:0] term_deskew;

	assign term_zeros  = {W{is_zeros}} & {W{1'b0}};
	assign term_ones   = {W{is_ones}} & {W{1'b1}};
	assign term_toggle = {W{is_toggle}} & toggle_word;
	assign term_ramp   = {W{is_ramp}} & st.ramp;
	assign term_single = {W{is_single}} & word_one;
	assign term_double = {W{is_double}} & double_word;
	assign term_deskew = {W{is_deskew}} & deskew_word;

	// ----------------------------------------
	// pattern mux
	// ----------------------------------------
	logic [W-1:0] pat;

	assign pat = term_zeros
	           | term_ones
	           | term_toggle
	           | term_ramp
	           | term_single
	           | term_double
	           | term_deskew;

	// ----------------------------------------
	// lane inputs
	// ----------------------------------------
	logic [W-1:0] lane_in   [LANES];
	logic [W-1:0] lane_next [LANES];

	assign lane_in[0] = i_sample_a;
	assign lane_in[1] = i_sample_b;

	// ----------------------------------------
	// per-channel output select
	// ----------------------------------------
	for (genvar c = 0; c < LANES; c++) begin : g_lane
		assign lane_next[c] = use_pat ? pat : lane_in[c];
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st       = st;
		next_st.phase = next_phase;
		next_st.ramp  = is_ramp ? ramp_step : {W{1'b0}};
		next_st.out_a = lane_next[0];
		next_st.out_b = lane_next[1];
		next_st.rdata = (i_rd & hit_any) ? rd_mux : tpg_pkg::READ_UNMAP;
		if (wr_sel) begin
			next_st.sel = wd_sel;
		end
		if (wr_one_hi) begin
			next_st.one_hi = wd_hi;
		end
		if (wr_one_lo) begin
			next_st.one_lo = wd_lo;
		end
		if (wr_two_hi) begin
			next_st.two_hi = wd_hi;
		end
		if (wr_two_lo) begin
			next_st.two_lo = wd_lo;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st.sel    <= tpg_pkg::SEL_RESET;
			st.one_hi <= tpg_pkg::BYTE_RESET;
			st.one_lo <= tpg_pkg::BYTE_RESET[tpg_pkg::LOW_LSB +: LO_W];
			st.two_hi <= tpg_pkg::BYTE_RESET;
			st.two_lo <= tpg_pkg::BYTE_RESET[tpg_pkg::LOW_LSB +: LO_W];
			st.ramp   <= {W{1'b0}};
			st.phase  <= 1'b0;
			st.rdata  <= tpg_pkg::READ_UNMAP;
			st.out_a  <= {W{1'b0}};
			st.out_b  <= {W{1'b0}};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_rdata    = st.rdata;
	assign o_sample_a = st.out_a;
	assign o_sample_b = st.out_b;
endmodule : adc_test_pattern_generator

/* bench/tpg_checker.sv */
// port assertions for the pattern generator
`timescale 1ns/1ns
module tpg_checker #(parameter int W = 14) (
	input wire logic         i_clk, i_rst, i_wr,
	input wire logic [7:0]   i_addr, i_wdata,
	input wire logic [W-1:0] i_sample_a, o_sample_a, i_sample_b, o_sample_b);
	logic [3:0]  s;
	logic [13:0] w;
	always_ff @(posedge i_clk) begin
		if (i_wr && i_addr == 8'h74) s <= i_wdata[7:4];
		if (i_wr && i_addr == 8'h75) w[13:6] <= i_wdata;
		if (i_wr && i_addr == 8'h76) w[5:0] <= i_wdata[7:2];
		if (i_rst) {s, w} <= 18'h00000;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_normal_pass: assert property (!$past(i_rst) && $past(s) == 4'h0 |->
		o_sample_a == $past(i_sample_a)) else $error("normal");
	a_lane_b_normal: assert property (!$past(i_rst) && $past(s) == 4'h0 |->
		o_sample_b == $past(i_sample_b)) else $error("lane b normal");
	a_lane_b_same: assert property ($past(s) inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8} |->
		o_sample_b == o_sample_a) else $error("lane b pattern");
	a_zero_words: assert property ($past(s) == 4'h1 |-> ~|o_sample_a) else $error("zero");
	a_one_words: assert property ($past(s) == 4'h2 |-> &o_sample_a) else $error("ones");
	a_deskew_all: assert property ($past(s) == 4'h8 |-> &o_sample_a) else $error("skew");
	a_single_word: assert property ($past(s) == 4'h6 |-> o_sample_a == $past(w))
		else $error("single");
	a_toggle_alt: assert property ($past(s, 2) == 4'h3 && $past(s) == 4'h3 |->
		o_sample_a inside {14'h2aaa, 14'h1555} && o_sample_a != $past(o_sample_a)) else $error("toggle");
	a_ramp_step: assert property ($past(s, 2) == 4'h4 && $past(s) == 4'h4 |->
		o_sample_a == W'($past(o_sample_a) + 1)) else $error("ramp");
	a_double_alt: assert property ($past(s, 2) == 4'h7 && $past(s) == 4'h7 |->
		(o_sample_a == $past(w)) != ($past(o_sample_a) == $past(w, 2))) else $error("double");
endmodule : tpg_checker
bind adc_test_pattern_generator tpg_checker #(.W(W)) tpg_checker_i (.*);

/* bench/sample_sink.sv */
// capture-side model registering the outgoing sample words
`timescale 1ns/1ns
module sample_sink (
	input wire logic i_clk, input wire logic [13:0] i_word, output logic [13:0] o_word);
	always_ff @(posedge i_clk) o_word <= i_word;
endmodule : sample_sink

/* bench/testbench.sv */
// self-checking bench for the pattern generator
`timescale 1ns/1ns
module testbench;
	logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic [13:0] i_sample_a = 14'h1234, i_sample_b = 14'h0abc, o_sample_a, o_sample_b, a, t;
	logic [15:0] regs [4] = '{16'h759c, 16'h7658, 16'h7711, 16'h78fc};
	logic [21:0] row [5] = '{22'h001234, 22'h040000, 22'h083fff, 22'h182716, 22'h203fff};
	int          failures = 0, n_tests = 0, cyc = 0;
	always #2 i_clk = ~i_clk;
	adc_test_pattern_generator #(.W(14)) adc_test_pattern_generator_i (.*);
	sample_sink sample_sink_i (.i_clk, .i_word(o_sample_a), .o_word(a));
	task automatic chk(input string n, input logic [13:0] e, g);
		n_tests++;
		if (g !== e) failures++;
		if (g !== e) $display("unexpected %s: expected %h seen %h", n, e, g);
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] ad, d);
		@(posedge i_clk) {i_wr, i_rd, i_addr, i_wdata} <= {wr, !wr, ad, d};
		@(posedge i_clk) {i_wr, i_rd} <= 2'b00;
		@(negedge i_clk) if (!wr) chk("read", {6'h00, d}, {6'h00, o_rdata});
	endtask : bus
	task automatic test_done(input int hung);
		$display("tests %0d failures %0d", n_tests, failures + hung);
		if (failures + hung == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge i_clk) if (++cyc == 20000) test_done(1);
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		bus(1'b0, 8'h74, 8'h00);
		foreach (regs[i]) bus(1'b1, regs[i][15:8], regs[i][7:0]);
		foreach (regs[i]) bus(1'b0, regs[i][15:8], regs[i][7:0]);
		bus(1'b0, 8'h79, 8'h00);
		foreach (row[i]) begin
			bus(1'b1, 8'h74, row[i][21:14]);
			repeat (2) @(negedge i_clk);
			chk("pattern", row[i][13:0], a);
			chk("lane b", (i == 0) ? 14'h0abc : row[i][13:0], o_sample_b);
		end
		bus(1'b1, 8'h74, 8'h30);
		repeat (2) @(negedge i_clk);
		t = a;
		chk("toggle set", 14'h0001, {13'h0000, t == 14'h2aaa || t == 14'h1555});
		@(negedge i_clk);
		chk("toggle", ~t, a);
		bus(1'b1, 8'h74, 8'h70);
		repeat (2) @(negedge i_clk);
		chk("double", 14'h0001, {13'h0000, a == 14'h047f || a == 14'h2716});
		bus(1'b1, 8'h74, 8'h40);
		repeat (16386) @(negedge i_clk);
		chk("ramp wrap", 14'h0000, a);
		@(posedge i_clk) i_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		foreach (regs[i]) bus(1'b0, regs[i][15:8], 8'h00);
		bus(1'b0, 8'h74, 8'h00);
		chk("reset normal", 14'h1234, a);
		test_done(0);
	end
endmodule : testbench
